// ### verilog/io_line_function_select.sv
// function assignment of the four digital io lines
`timescale 1ns/1ps
`include "io_line_params.svh"

// What this block does
// - Each line has its own 16-bit selector and code 1 makes it a general input.
// - Code 2 makes the line a fault reset input that acts only in local control mode.
// - Code 3 makes the line a power stage enable input honoured only in local control mode.
// - Code 4 makes the line a halt request input.
// - Codes 9, 10 and 11 make the line jog positive, jog negative and jog fast/slow.
// - Code 20 makes the line the reference switch input on any of the four lines.
// - Code 21, positive limit switch, is accepted only on the first line.
// - Code 22, negative limit switch, is accepted only on the second line.
// - Codes 101, 102 and 103 make the line an output of a software value, no-fault or active.
// - Selector writes are accepted only while the power stage is disabled.
// - A stored selector takes effect only at the next power-up.
// - Factory defaults are positive limit, negative limit, general input and reference switch.
// - Levels of lines set as general inputs are readable as the line input state.
module io_line_function_select
    import io_line_pkg::*;
(
    // clock, reset and power-up
    input  wire logic                   mclk_i,
    input  wire logic                   rst_i,
    input  wire logic                   power_up_i,
    // parameter access
    input  wire io_line_pkg::par_req_type par_req_i,
    output io_line_pkg::par_rsp_type    par_rsp_o,
    // drive status
    input  wire logic                   power_stage_enabled_i,
    input  wire logic                   local_mode_i,
    input  wire logic                   no_fault_i,
    input  wire logic                   drive_active_i,
    // io line pins
    input  wire logic [3:0]             line_in_i,
    output logic [3:0]                  line_out_o,
    output logic [3:0]                  line_oe_o,
    // input functions to the drive core
    output io_line_pkg::in_func_type    in_func_o
);
    import io_line_pkg::*;

    // which codes a given line accepts
    function automatic logic code_ok(input logic [1:0] line, input logic [15:0] code);
        case (code)
            `FN_GP_INPUT, `FN_FAULT_RESET, `FN_ENABLE, `FN_HALT,
            `FN_JOG_POS, `FN_JOG_NEG, `FN_JOG_FAST, `FN_REF_SWITCH,
            `FN_GP_OUTPUT, `FN_NO_FAULT, `FN_ACTIVE: code_ok = 1'b1;
            `FN_LIMIT_POS: code_ok = (line == 2'd0);
            `FN_LIMIT_NEG: code_ok = (line == 2'd1);
            default:       code_ok = 1'b0;
        endcase
    endfunction : code_ok

    // stored copy survives power_up_i; the active copy is what the pins obey
    logic [15:0]  stored    [4];
    logic [15:0]  active    [4];
    logic [3:0]   out_value;
    par_rsp_type  rsp;
    in_func_type  func;
    logic [3:0]   pin_out;
    logic [3:0]   pin_oe;

    // address decode
    logic [3:0]   sel_hit;
    logic         state_hit;
    logic         outv_hit;
    logic [1:0]   sel_idx;
    logic         any_sel;
    logic         wr_ok;
    assign sel_hit[0] = (par_req_i.addr == `ADDR_LINE1_SEL);
    assign sel_hit[1] = (par_req_i.addr == `ADDR_LINE2_SEL);
    assign sel_hit[2] = (par_req_i.addr == `ADDR_LINE3_SEL);
    assign sel_hit[3] = (par_req_i.addr == `ADDR_LINE4_SEL);
    assign state_hit  = (par_req_i.addr == `ADDR_LINE_STATE);
    assign outv_hit   = (par_req_i.addr == `ADDR_OUT_VALUE);
    assign any_sel    = |sel_hit;
    assign sel_idx    = sel_hit[3] ? 2'd3 : sel_hit[2] ? 2'd2 : sel_hit[1] ? 2'd1 : 2'd0;
    // writing while the power stage runs could retarget a limit switch under motion
    assign wr_ok      = par_req_i.wr && any_sel && !power_stage_enabled_i
                        && code_ok(sel_idx, par_req_i.wdata);

    // general input levels, masked to lines configured as such
    logic [3:0] gp_level;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_line
            assign gp_level[g] = line_in_i[g] && (active[g] == `FN_GP_INPUT);
            assign pin_oe[g]   = (active[g] == `FN_GP_OUTPUT) || (active[g] == `FN_NO_FAULT)
                                 || (active[g] == `FN_ACTIVE);
            assign pin_out[g]  = (active[g] == `FN_GP_OUTPUT) ? out_value[g]
                               : (active[g] == `FN_NO_FAULT)  ? no_fault_i
                               : (active[g] == `FN_ACTIVE)    ? drive_active_i : 1'b0;
        end
    endgenerate

    // input function gathering over all lines
    in_func_type next_func;
    always_comb begin
        next_func = '0;
        for (int i = 0; i < 4; i++) begin
            if (line_in_i[i]) begin
                case (active[i])
                    `FN_FAULT_RESET: next_func.fault_reset = local_mode_i;
                    `FN_ENABLE:      next_func.enable      = local_mode_i;
                    `FN_HALT:        next_func.halt        = 1'b1;
                    `FN_JOG_POS:     next_func.jog_pos     = 1'b1;
                    `FN_JOG_NEG:     next_func.jog_neg     = 1'b1;
                    `FN_JOG_FAST:    next_func.jog_fast    = 1'b1;
                    `FN_REF_SWITCH:  next_func.ref_switch  = 1'b1;
                    `FN_LIMIT_POS:   next_func.positive_travel_limit = (i == 0);
                    `FN_LIMIT_NEG:   next_func.negative_travel_limit = (i == 1);
                    default:         ;
                endcase
            end
        end
    end

    // read data and answer
    par_rsp_type next_rsp;
    always_comb begin
        next_rsp       = '0;
        next_rsp.ack   = par_req_i.rd || par_req_i.wr;
        if (par_req_i.rd) begin
            if (any_sel)        next_rsp.rdata = stored[sel_idx];
            else if (state_hit) next_rsp.rdata = {12'h000, gp_level};
            else if (outv_hit)  next_rsp.rdata = {12'h000, out_value};
            else                next_rsp.err   = 1'b1;
        end else if (par_req_i.wr) begin
            next_rsp.err = !(wr_ok || outv_hit);
        end
    end

    // stored selectors, factory defaults on reset
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            stored[0] <= `RST_LINE1_SEL;
            stored[1] <= `RST_LINE2_SEL;
            stored[2] <= `RST_LINE3_SEL;
            stored[3] <= `RST_LINE4_SEL;
        end else if (wr_ok) begin
            stored[sel_idx] <= par_req_i.wdata;
        end
    end

    // active selectors take factory defaults on reset and reload from stored only at power-up
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            active[0] <= `RST_LINE1_SEL;
            active[1] <= `RST_LINE2_SEL;
            active[2] <= `RST_LINE3_SEL;
            active[3] <= `RST_LINE4_SEL;
        end else if (power_up_i) begin
            active <= stored;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            out_value  <= `RST_OUT_VALUE;
            rsp        <= '0;
            func       <= '0;
            line_out_o <= 4'h0;
            line_oe_o  <= 4'h0;
        end else begin
            if (par_req_i.wr && outv_hit) out_value <= par_req_i.wdata[3:0];
            rsp        <= next_rsp;
            func       <= next_func;
            line_out_o <= pin_out;
            line_oe_o  <= pin_oe;
        end
    end

    assign par_rsp_o = rsp;
    assign in_func_o = func;

    // checks
    property p_write_blocked;
        @(posedge mclk_i) disable iff (rst_i)
        (par_req_i.wr && any_sel && power_stage_enabled_i)
            |=> $stable(stored[0]) && $stable(stored[1]) && $stable(stored[2]) && $stable(stored[3]);
    endproperty
    a_write_blocked: assert property (p_write_blocked) else $error("selector changed while power on");

    property p_bad_code;
        @(posedge mclk_i) disable iff (rst_i)
        (par_req_i.wr && !par_req_i.rd && sel_hit[2] && par_req_i.wdata == `FN_LIMIT_POS)
            |=> $stable(stored[2]) && rsp.err;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("limit code accepted on line three");

    property p_hold_active;
        @(posedge mclk_i) disable iff (rst_i)
        !power_up_i |=> $stable(active[0]) && $stable(active[1]) && $stable(active[2]) && $stable(active[3]);
    endproperty
    a_hold_active: assert property (p_hold_active) else $error("active selector changed without power-up");

    property p_power_up;
        @(posedge mclk_i) disable iff (rst_i)
        power_up_i |=> active[0] == $past(stored[0]) && active[3] == $past(stored[3]);
    endproperty
    a_power_up: assert property (p_power_up) else $error("power-up did not load stored selectors");

    property p_fault_reset_local;
        @(posedge mclk_i) disable iff (rst_i)
        in_func_o.fault_reset |-> $past(local_mode_i) && $past(line_in_i) != 4'h0;
    endproperty
    a_fault_reset_local: assert property (p_fault_reset_local) else $error("fault reset outside local mode");

    property p_enable_local;
        @(posedge mclk_i) disable iff (rst_i)
        !local_mode_i |=> !in_func_o.enable;
    endproperty
    a_enable_local: assert property (p_enable_local) else $error("enable outside local mode");

    property p_limit_pos;
        @(posedge mclk_i) disable iff (rst_i)
        (active[0] == `FN_LIMIT_POS && line_in_i[0]) |=> in_func_o.positive_travel_limit;
    endproperty
    a_limit_pos: assert property (p_limit_pos) else $error("positive limit not passed from line one");

    property p_halt;
        @(posedge mclk_i) disable iff (rst_i)
        (active[2] == `FN_HALT && line_in_i[2]) |=> in_func_o.halt;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not passed");

    property p_no_fault_out;
        @(posedge mclk_i) disable iff (rst_i)
        (active[2] == `FN_NO_FAULT) |=> line_oe_o[2] && line_out_o[2] == $past(no_fault_i);
    endproperty
    a_no_fault_out: assert property (p_no_fault_out) else $error("no-fault output wrong");

    property p_gp_state;
        @(posedge mclk_i) disable iff (rst_i)
        (par_req_i.rd && state_hit && active[2] == `FN_GP_INPUT) |=> par_rsp_o.rdata[2] == $past(line_in_i[2]);
    endproperty
    a_gp_state: assert property (p_gp_state) else $error("line state read wrong");

    property p_limit_neg;
        @(posedge mclk_i) disable iff (rst_i)
        (active[1] == `FN_LIMIT_NEG && line_in_i[1]) |=> in_func_o.negative_travel_limit;
    endproperty
    a_limit_neg: assert property (p_limit_neg) else $error("negative limit not passed from line two");

    property p_limit_neg_reject;
        @(posedge mclk_i) disable iff (rst_i)
        (par_req_i.wr && !par_req_i.rd && sel_hit[0] && par_req_i.wdata == `FN_LIMIT_NEG)
            |=> $stable(stored[0]) && par_rsp_o.err;
    endproperty
    a_limit_neg_reject: assert property (p_limit_neg_reject) else $error("negative limit taken on line one");

    property p_ref_switch;
        @(posedge mclk_i) disable iff (rst_i)
        (active[3] == `FN_REF_SWITCH && line_in_i[3]) |=> in_func_o.ref_switch;
    endproperty
    a_ref_switch: assert property (p_ref_switch) else $error("reference switch not passed");

    property p_jog_pos;
        @(posedge mclk_i) disable iff (rst_i)
        (active[3] == `FN_JOG_POS && line_in_i[3]) |=> in_func_o.jog_pos;
    endproperty
    a_jog_pos: assert property (p_jog_pos) else $error("jog positive not passed");

    property p_jog_fast;
        @(posedge mclk_i) disable iff (rst_i)
        (active[3] == `FN_JOG_FAST && line_in_i[3]) |=> in_func_o.jog_fast;
    endproperty
    a_jog_fast: assert property (p_jog_fast) else $error("jog speed choice not passed");

    property p_enable_pass;
        @(posedge mclk_i) disable iff (rst_i)
        (active[3] == `FN_ENABLE && line_in_i[3] && local_mode_i) |=> in_func_o.enable;
    endproperty
    a_enable_pass: assert property (p_enable_pass) else $error("enable not passed in local mode");

    property p_fault_reset_pass;
        @(posedge mclk_i) disable iff (rst_i)
        (active[3] == `FN_FAULT_RESET && line_in_i[3] && local_mode_i) |=> in_func_o.fault_reset;
    endproperty
    a_fault_reset_pass: assert property (p_fault_reset_pass) else $error("fault reset not passed in local mode");

    property p_factory;
        @(posedge mclk_i) disable iff (rst_i)
        $fell(rst_i) |-> active[0] == `RST_LINE1_SEL && active[1] == `RST_LINE2_SEL
                         && active[2] == `RST_LINE3_SEL && active[3] == `RST_LINE4_SEL;
    endproperty
    a_factory: assert property (p_factory) else $error("factory functions not active after reset");

    property p_write_ok;
        @(posedge mclk_i) disable iff (rst_i)
        (par_req_i.wr && !par_req_i.rd && sel_hit[2] && !power_stage_enabled_i && par_req_i.wdata == `FN_HALT)
            |=> stored[2] == `FN_HALT && par_rsp_o.ack && !par_rsp_o.err;
    endproperty
    a_write_ok: assert property (p_write_ok) else $error("legal selector write not stored");

    property p_active_out;
        @(posedge mclk_i) disable iff (rst_i)
        (active[2] == `FN_ACTIVE) |=> line_oe_o[2] && line_out_o[2] == $past(drive_active_i);
    endproperty
    a_active_out: assert property (p_active_out) else $error("active output wrong");

    property p_gp_out;
        @(posedge mclk_i) disable iff (rst_i)
        (active[2] == `FN_GP_OUTPUT) |=> line_oe_o[2] && line_out_o[2] == $past(out_value[2]);
    endproperty
    a_gp_out: assert property (p_gp_out) else $error("software output wrong");

    property p_input_no_drive;
        @(posedge mclk_i) disable iff (rst_i)
        (active[2] == `FN_GP_INPUT) |=> !line_oe_o[2];
    endproperty
    a_input_no_drive: assert property (p_input_no_drive) else $error("general input line driven");

endmodule : io_line_function_select

// ### verilog/io_line_params.svh
// constants for the io line function selector block
`ifndef IO_LINE_PARAMS_SVH
`define IO_LINE_PARAMS_SVH

`define LINE_COUNT          4
`define SEL_WIDTH           16
`define PAR_ADDR_WIDTH      16

// parameter addresses
`define ADDR_LINE1_SEL      16'h0722
`define ADDR_LINE2_SEL      16'h0724
`define ADDR_LINE3_SEL      16'h0726
`define ADDR_LINE4_SEL      16'h0728
`define ADDR_LINE_STATE     16'h072A
`define ADDR_OUT_VALUE      16'h072C

// selector codes
`define FN_GP_INPUT         16'h0001
`define FN_FAULT_RESET      16'h0002
`define FN_ENABLE           16'h0003
`define FN_HALT             16'h0004
`define FN_JOG_POS          16'h0009
`define FN_JOG_NEG          16'h000A
`define FN_JOG_FAST         16'h000B
`define FN_REF_SWITCH       16'h0014
`define FN_LIMIT_POS        16'h0015
`define FN_LIMIT_NEG        16'h0016
`define FN_GP_OUTPUT        16'h0065
`define FN_NO_FAULT         16'h0066
`define FN_ACTIVE           16'h0067

// factory defaults per line
`define RST_LINE1_SEL       16'h0015
`define RST_LINE2_SEL       16'h0016
`define RST_LINE3_SEL       16'h0001
`define RST_LINE4_SEL       16'h0014
`define RST_OUT_VALUE       4'h0

`endif

// ### verilog/io_line_pkg.sv
// types shared by the io line function selector block
package io_line_pkg;

    // parameter access request from the fieldbus side
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } par_req_type;

    // parameter access answer
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } par_rsp_type;

    // input functions delivered to the drive core
    typedef struct packed {
        logic fault_reset;
        logic enable;
        logic halt;
        logic jog_pos;
        logic jog_neg;
        logic jog_fast;
        logic ref_switch;
        logic positive_travel_limit;
        logic negative_travel_limit;
    } in_func_type;

endpackage : io_line_pkg

// ### testbench/io_switch_model.sv
// switch and sensor model wired to the four io lines
`timescale 1ns/1ps
module io_switch_model (
    // switch contact levels set by the bench
    input  wire logic [3:0] switch_level_i,
    // device pin drive
    input  wire logic [3:0] line_out_i,
    input  wire logic [3:0] line_oe_i,
    // resolved line level
    output logic      [3:0] line_o
);
    // contacts sit behind series resistors, so a driving device wins the line
    assign line_o = (line_oe_i & line_out_i) | (~line_oe_i & switch_level_i);
endmodule : io_switch_model

// ### testbench/io_line_function_select_bench.sv
// self-checking bench of the io line function selector
`timescale 1ns/1ps
`include "io_line_params.svh"
module io_line_function_select_bench;
    import io_line_pkg::*;
    logic        mclk_i                = 1'h0;
    logic        rst_i                 = 1'h1;
    logic        power_up_i            = 1'h0;
    par_req_type par_req_i             = '0;
    par_rsp_type par_rsp_o;
    logic        power_stage_enabled_i = 1'h0;
    logic        local_mode_i          = 1'h1;
    logic        no_fault_i            = 1'h0;
    logic        drive_active_i        = 1'h0;
    logic [3:0]  switch_level          = 4'h0;
    logic [3:0]  line_in_i;
    logic [3:0]  line_out_o;
    logic [3:0]  line_oe_o;
    in_func_type in_func_o;
    int          bad_count             = 0;
    int          compares              = 0;
    logic [15:0] dflt [4] = '{`RST_LINE1_SEL, `RST_LINE2_SEL, `RST_LINE3_SEL, `RST_LINE4_SEL};
    logic [15:0] codes [7] = '{`FN_FAULT_RESET, `FN_ENABLE, `FN_HALT, `FN_JOG_POS, `FN_JOG_NEG,
                               `FN_JOG_FAST, `FN_REF_SWITCH};

    io_line_function_select i_io_line_function_select (.mclk_i(mclk_i), .rst_i(rst_i),
        .power_up_i(power_up_i), .par_req_i(par_req_i), .par_rsp_o(par_rsp_o),
        .power_stage_enabled_i(power_stage_enabled_i), .local_mode_i(local_mode_i),
        .no_fault_i(no_fault_i), .drive_active_i(drive_active_i), .line_in_i(line_in_i),
        .line_out_o(line_out_o), .line_oe_o(line_oe_o), .in_func_o(in_func_o));
    io_switch_model i_io_switch_model (.switch_level_i(switch_level), .line_out_i(line_out_o),
        .line_oe_i(line_oe_o), .line_o(line_in_i));

    always #4 mclk_i = ~mclk_i;

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // one request cycle; the answer stands in the following cycle only, then one idle cycle
    task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                          input logic exp_err, input logic [15:0] exp_rd);
        par_req_i = '{rd: !wr, wr: wr, addr: addr, wdata: data};
        @(negedge mclk_i);
        par_req_i = '0;
        check("ack", 16'h0001, {15'h0000, par_rsp_o.ack});
        check("err", {15'h0000, exp_err}, {15'h0000, par_rsp_o.err});
        if (!wr) check("rdata", exp_rd, par_rsp_o.rdata);
        @(negedge mclk_i);
    endtask : access

    task automatic power_cycle;
        power_up_i = 1'h1;
        @(negedge mclk_i);
        power_up_i = 1'h0;
        repeat (2) @(negedge mclk_i);
    endtask : power_cycle

    task automatic settle(input logic [3:0] pins);
        switch_level = pins;
        repeat (2) @(negedge mclk_i);
    endtask : settle

    task automatic finish_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    // generous bound: the sequence needs under 150 cycles
    initial begin
        repeat (5000) @(posedge mclk_i);
        bad_count++;
        finish_test();
    end

    initial begin
        repeat (5) @(negedge mclk_i);
        rst_i = 1'h0;
        @(negedge mclk_i);
        for (int i = 0; i < 4; i++) access(1'h0, `ADDR_LINE1_SEL + 16'(2 * i), 16'h0000, 1'h0, dflt[i]);
        settle(4'hB);
        check("factory functions", 16'h0007, {7'h00, in_func_o});
        settle(4'hF);
        access(1'h0, `ADDR_LINE_STATE, 16'h0000, 1'h0, 16'h0004);
        power_stage_enabled_i = 1'h1;
        access(1'h1, `ADDR_LINE3_SEL, `FN_HALT, 1'h1, 16'h0000);
        power_stage_enabled_i = 1'h0;
        access(1'h1, `ADDR_LINE3_SEL, `FN_LIMIT_POS, 1'h1, 16'h0000);
        access(1'h1, `ADDR_LINE2_SEL, `FN_LIMIT_POS, 1'h1, 16'h0000);
        access(1'h1, `ADDR_LINE1_SEL, `FN_LIMIT_NEG, 1'h1, 16'h0000);
        access(1'h1, `ADDR_LINE4_SEL, 16'h0005, 1'h1, 16'h0000);
        access(1'h1, `ADDR_LINE_STATE, 16'h0001, 1'h1, 16'h0000);
        access(1'h0, 16'h0730, 16'h0000, 1'h1, 16'h0000);
        access(1'h0, `ADDR_LINE1_SEL, 16'h0000, 1'h0, `FN_LIMIT_POS);
        access(1'h0, `ADDR_LINE3_SEL, 16'h0000, 1'h0, `FN_GP_INPUT);
        // power stage stays disabled from here on, so every selector write is legal
        access(1'h1, `ADDR_LINE3_SEL, `FN_HALT, 1'h0, 16'h0000);
        access(1'h0, `ADDR_LINE3_SEL, 16'h0000, 1'h0, `FN_HALT);
        settle(4'h4);
        check("halt before power-up", 16'h0000, {7'h00, in_func_o});
        access(1'h0, `ADDR_LINE_STATE, 16'h0000, 1'h0, 16'h0004);
        power_cycle();
        check("halt after power-up", 16'h0040, {7'h00, in_func_o});
        access(1'h0, `ADDR_LINE_STATE, 16'h0000, 1'h0, 16'h0000);
        settle(4'h0);
        for (int i = 0; i < 7; i++) begin
            access(1'h1, `ADDR_LINE4_SEL, codes[i], 1'h0, 16'h0000);
            power_cycle();
            settle(4'h8);
            check("input function", 16'h0100 >> i, {7'h00, in_func_o});
            local_mode_i = 1'h0;
            repeat (2) @(negedge mclk_i);
            check("remote mode", (i < 2) ? 16'h0000 : 16'h0100 >> i, {7'h00, in_func_o});
            local_mode_i = 1'h1;
        end
        access(1'h1, `ADDR_OUT_VALUE, 16'h0004, 1'h0, 16'h0000);
        access(1'h0, `ADDR_OUT_VALUE, 16'h0000, 1'h0, 16'h0004);
        for (int i = 0; i < 3; i++) begin
            access(1'h1, `ADDR_LINE3_SEL, `FN_GP_OUTPUT + 16'(i), 1'h0, 16'h0000);
            no_fault_i = 1'h1;
            drive_active_i = 1'h0;
            power_cycle();
            check("output enable", 16'h0004, {12'h000, line_oe_o});
            check("output a", (i != 2) ? 16'h0004 : 16'h0000, {12'h000, line_out_o});
            no_fault_i = 1'h0;
            drive_active_i = 1'h1;
            repeat (2) @(negedge mclk_i);
            check("output b", (i != 1) ? 16'h0004 : 16'h0000, {12'h000, line_out_o});
        end
        finish_test();
    end
endmodule : io_line_function_select_bench
